// [src/irq_ctrl_regs.svh]
// register offsets, field positions and reset values of the interrupt controller
// assumes byte addresses on a 32-bit wishbone bus, one aligned word per register
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// register offsets (byte addresses)
`define OFS_FAST_STATUS   12'h000
`define OFS_NORMAL_STATUS 12'h004
`define OFS_RAW_STATUS    12'h008
`define OFS_CLASS_SELECT  12'h00c
`define OFS_ENABLE        12'h010
`define OFS_VECTOR_ADDR   12'h014
`define OFS_DEFAULT_ADDR  12'h018
`define OFS_NONVEC_STATUS 12'h01c
`define OFS_EVT_STATUS    12'h020
`define OFS_EVT_CLEAR     12'h024
`define OFS_EVT_ENABLE    12'h028
`define OFS_SLOT_ADDR     12'h100
`define OFS_SLOT_CTRL     12'h200

// slot blocks span 16 words: address bits above the word index
`define SLOT_BLOCK_MASK   12'hfc0

// slot control fields
`define SLOT_SRC_LSB      0
`define SLOT_SRC_MSB      4
`define SLOT_EN_BIT       5

// event bits
`define EVT_FAST_RISE     0
`define EVT_NORMAL_RISE   1
`define EVT_SPURIOUS      2

// reset values
`define RST_CLASS_SELECT  32'h0000_0000
`define RST_ENABLE        32'h0000_0000
`define RST_DEFAULT_ADDR  32'h0000_0000
`define RST_SLOT_ADDR     32'h0000_0000
`define RST_SLOT_CTRL     6'h00
`define RST_EVT           3'h0

`endif

// [src/irq_types_pkg.sv]
// types shared by the interrupt controller and its slot priority resolver
// assumes 32 request sources and 16 vectored slots
`default_nettype none

package irq_types_pkg;

    localparam int NUM_SOURCES = 32;
    localparam int NUM_SLOTS   = 16;
    localparam int NUM_EVENTS  = 3;

    typedef logic [NUM_SOURCES-1:0] source_vec_t;
    typedef logic [4:0]             source_idx_t;
    typedef logic [NUM_SLOTS-1:0]   slot_vec_t;
    typedef logic [3:0]             slot_idx_t;
    typedef logic [NUM_EVENTS-1:0]  event_vec_t;
    typedef logic [31:0]            word_t;

    // one vectored slot: which source it serves and whether it is live
    typedef struct packed
    {
        logic        enable;
        source_idx_t source;
    } slot_ctrl_s;

endpackage

`default_nettype wire

// [src/slot_match_if.sv]
// carrier between the controller and its slot priority resolver
// assumes both ends sit in the same clock domain and are purely combinational
`timescale 1ns/1ps
`default_nettype none

interface slot_match_if;
    import irq_types_pkg::*;

    slot_vec_t hit;     // slots whose source is requesting
    logic      any;     // at least one slot requesting
    slot_idx_t winner;  // lowest requesting slot number

    modport requester
    (
        output hit,
        input  any,
        input  winner
    );

    modport resolver
    (
        input  hit,
        output any,
        output winner
    );
endinterface

`default_nettype wire

// [src/slot_priority.sv]
// fixed-priority resolver for the vectored slots, slot 0 first
// assumes hit is already qualified by enables and class
`timescale 1ns/1ps
`default_nettype none

module slot_priority
(
    // slot requests in, winner out
    slot_match_if.resolver m
);
    import irq_types_pkg::*;

    // scan downward so the lowest requesting slot is the last one kept
    function automatic slot_idx_t first_set(input slot_vec_t v);
        slot_idx_t r;
        r = '0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--)
        begin
            if (v[i])
                r = slot_idx_t'(i);
        end
        return r;
    endfunction

    // priority pick and any flag
    assign m.winner = first_set(m.hit);
    assign m.any    = |m.hit;
endmodule

`default_nettype wire

// [src/vectored_interrupt_controller.sv]
// prioritising interrupt controller with fast, vectored and non-vectored classes
// assumes request lines from on-chip peripherals on the same clock, level sensitive,
// and a classic wishbone master for register access
//
// Overview of operation
// - software class bits put each source in fast or normal; slots make vectored.
// - fast requests beat all normal ones; they never enter vector selection.
// - all active fast-class requests are ORed onto the single fast output.
// - a status word shows which fast-class sources are requesting now.
// - sixteen slots take any source; slot 0 highest, slot 15 lowest.
// - non-vectored normal requests rank below every slot and every fast request.
// - normal output is high while any vectored or non-vectored request is active.
// - vector read returns the address of the best pending vectored slot.
// - with no vectored request pending, vector read returns the default address.
// - a second status word shows which normal-class requests are active.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module vectored_interrupt_controller
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        srst,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [11:0]                 wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // peripheral request lines
    input  wire irq_types_pkg::source_vec_t  irq_source,
    // processor core requests
    output logic                             fast_interrupt_request,
    output logic                             normal_interrupt_request,
    // controller event interrupt
    output logic                             event_interrupt
);
    import irq_types_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // merge write data into a word under the byte selects
    function automatic word_t merge_sel(input word_t old, input word_t dat,
                                        input logic [3:0] sel);
        word_t r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[b*8 +: 8] = dat[b*8 +: 8];
        end
        return r;
    endfunction

    // true when the address lies in a 16-word slot block
    function automatic logic in_block(input logic [11:0] adr, input logic [11:0] base);
        return (adr & `SLOT_BLOCK_MASK) == base;
    endfunction

    // word index inside a slot block
    function automatic slot_idx_t slot_of(input logic [11:0] adr);
        return adr[5:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers

    source_vec_t class_select;          // 1 = fast class
    source_vec_t enable;
    word_t       default_addr;
    word_t       slot_addr [NUM_SLOTS];
    slot_ctrl_s  slot_ctrl [NUM_SLOTS];
    event_vec_t  evt_status;
    event_vec_t  evt_enable;
    logic        fast_q;
    logic        normal_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic        bus_req;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [11:0] adr;
    slot_idx_t   adr_slot;
    logic        hit_slot_addr;
    logic        hit_slot_ctrl;
    logic        wr_class;
    logic        wr_enable;
    logic        wr_default;
    logic        wr_evt_clear;
    logic        wr_evt_enable;
    logic        wr_slot_addr;
    logic        wr_slot_ctrl;
    logic        rd_vector;
    logic        hit_fast_status;
    logic        hit_normal_status;
    logic        hit_raw_status;
    logic        hit_class;
    logic        hit_enable;
    logic        hit_vector;
    logic        hit_default;
    logic        hit_nonvec;
    logic        hit_evt_status;
    logic        hit_evt_clear;
    logic        hit_evt_enable;

    // a new request is taken once, in the cycle before ack
    // cyc and stb still high after ack start a second transfer one cycle later
    assign bus_req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_strobe     = bus_req & wb_we_i;
    assign rd_strobe     = bus_req & ~wb_we_i;
    assign adr           = {wb_adr_i[11:2], 2'b00};
    assign adr_slot      = slot_of(adr);
    assign hit_slot_addr = in_block(adr, `OFS_SLOT_ADDR);
    assign hit_slot_ctrl = in_block(adr, `OFS_SLOT_CTRL);

    // one named hit per single-word register, shared by writes and reads
    assign hit_fast_status   = (adr == `OFS_FAST_STATUS);
    assign hit_normal_status = (adr == `OFS_NORMAL_STATUS);
    assign hit_raw_status    = (adr == `OFS_RAW_STATUS);
    assign hit_class         = (adr == `OFS_CLASS_SELECT);
    assign hit_enable        = (adr == `OFS_ENABLE);
    assign hit_vector        = (adr == `OFS_VECTOR_ADDR);
    assign hit_default       = (adr == `OFS_DEFAULT_ADDR);
    assign hit_nonvec        = (adr == `OFS_NONVEC_STATUS);
    assign hit_evt_status    = (adr == `OFS_EVT_STATUS);
    assign hit_evt_clear     = (adr == `OFS_EVT_CLEAR);
    assign hit_evt_enable    = (adr == `OFS_EVT_ENABLE);

    // write strobes per register; status and vector words ignore writes
    assign wr_class      = wr_strobe & hit_class;
    assign wr_enable     = wr_strobe & hit_enable;
    assign wr_default    = wr_strobe & hit_default;
    assign wr_evt_clear  = wr_strobe & hit_evt_clear;
    assign wr_evt_enable = wr_strobe & hit_evt_enable;
    assign wr_slot_addr  = wr_strobe & hit_slot_addr;
    assign wr_slot_ctrl  = wr_strobe & hit_slot_ctrl;
    assign rd_vector     = rd_strobe & hit_vector;

    ////////////////////////////////////////////////////////////////////////////
    // request classification

    source_vec_t active;
    source_vec_t fast_active;
    source_vec_t normal_active;
    source_vec_t slotted;
    source_vec_t nonvec_active;

    // gate each line by its enable; levels pass straight through
    assign active        = irq_source & enable;
    assign fast_active   = active & class_select;
    assign normal_active = active & ~class_select;

    // sources owned by a live slot are vectored, the rest non-vectored
    // a source held by any live slot counts as vectored, even a low-priority one
    always_comb
    begin
        slotted = '0;
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (slot_ctrl[i].enable)
                slotted[slot_ctrl[i].source] = 1'b1;
        end
    end

    assign nonvec_active = normal_active & ~slotted;

    ////////////////////////////////////////////////////////////////////////////
    // vectored slot priority

    slot_match_if match ();

    // a slot requests only for a normal-class source, fast never counts
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++)
        begin : g_slot
            assign match.hit[g] = slot_ctrl[g].enable
                                & normal_active[slot_ctrl[g].source];
        end
    endgenerate

    slot_priority u_priority
    (
        .m (match)
    );

    // vector choice: best slot, else the shared default routine
    // the default routine must then look at the non-vectored status word
    word_t vector_addr;
    assign vector_addr = match.any ? slot_addr[match.winner]
                                   : default_addr;

    ////////////////////////////////////////////////////////////////////////////
    // core request outputs

    // fast merges every fast source; normal merges vectored and non-vectored
    // no flip-flop on either path, so both drop in the cycle the lines drop
    assign fast_interrupt_request   = |fast_active;
    assign normal_interrupt_request = |normal_active;

    ////////////////////////////////////////////////////////////////////////////
    // events and event interrupt

    event_vec_t evt_new;
    event_vec_t evt_clr;
    event_vec_t next_evt_status;

    // rising edges of the core requests and vector reads with no normal request pending
    // a spurious read means a normal request vanished before software got to it
    assign evt_new[`EVT_FAST_RISE]   = fast_interrupt_request & ~fast_q;
    assign evt_new[`EVT_NORMAL_RISE] = normal_interrupt_request & ~normal_q;
    assign evt_new[`EVT_SPURIOUS]    = rd_vector & ~normal_interrupt_request;
    assign evt_clr = wr_evt_clear ? wb_dat_i[NUM_EVENTS-1:0] : '0;

    // a fresh event survives a clear in the same cycle
    assign next_evt_status = (evt_status & ~evt_clr) | evt_new;
    assign event_interrupt = |(evt_status & evt_enable);

    // edge trackers and sticky status
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            fast_q     <= 1'b0;
            normal_q   <= 1'b0;
            evt_status <= `RST_EVT;
        end
        else
        begin
            fast_q     <= fast_interrupt_request;
            normal_q   <= normal_interrupt_request;
            evt_status <= next_evt_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register writes

    // class, enable, default address and event enable
    // a class or enable change reaches the core outputs in the cycle after the write
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            class_select <= `RST_CLASS_SELECT;
            enable       <= `RST_ENABLE;
            default_addr <= `RST_DEFAULT_ADDR;
            evt_enable   <= `RST_EVT;
        end
        else
        begin
            if (wr_class)
                class_select <= merge_sel(class_select, wb_dat_i, wb_sel_i);
            if (wr_enable)
                enable <= merge_sel(enable, wb_dat_i, wb_sel_i);
            if (wr_default)
                default_addr <= merge_sel(default_addr, wb_dat_i, wb_sel_i);
            if (wr_evt_enable && wb_sel_i[0])
                evt_enable <= wb_dat_i[NUM_EVENTS-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slot register writes

    word_t slot_ctrl_word;
    assign slot_ctrl_word = merge_sel(32'h0000_0000, wb_dat_i, wb_sel_i);

    // per-slot service address and source assignment, changeable at run time
    // slot control needs byte lane 0; the upper lanes of that word are ignored
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
            begin
                slot_addr[i] <= `RST_SLOT_ADDR;
                slot_ctrl[i] <= `RST_SLOT_CTRL;
            end
        end
        else
        begin
            if (wr_slot_addr)
                slot_addr[adr_slot] <= merge_sel(slot_addr[adr_slot], wb_dat_i, wb_sel_i);
            if (wr_slot_ctrl && wb_sel_i[0])
                slot_ctrl[adr_slot] <= slot_ctrl_word[`SLOT_EN_BIT:`SLOT_SRC_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    word_t rd_slot_ctrl;
    word_t rd_data;

    assign rd_slot_ctrl = {26'h0, slot_ctrl[adr_slot]};

    // unmapped and write-only addresses read as zero
    assign rd_data =
        hit_fast_status   ? fast_active   :
        hit_normal_status ? normal_active :
        hit_raw_status    ? irq_source    :
        hit_class         ? class_select  :
        hit_enable        ? enable        :
        hit_vector        ? vector_addr   :
        hit_default       ? default_addr  :
        hit_nonvec        ? nonvec_active :
        hit_evt_status    ? {29'h0, evt_status} :
        hit_evt_enable    ? {29'h0, evt_enable} :
        hit_slot_addr     ? slot_addr[adr_slot] :
        hit_slot_ctrl     ? rd_slot_ctrl  :
                            32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // bus answer

    // ack one cycle after the request, every address answered
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (rd_strobe)
                wb_dat_o <= rd_data;
        end
    end
endmodule

`default_nettype wire

// [tb/irq_ctrl_properties.sv]
// concurrent checks on the interrupt controller's top-level ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl_properties
(
    // clock and reset
    input wire logic                       clock,
    input wire logic                       srst,
    // wishbone slave side
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [11:0]                wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    // request lines and outputs
    input wire irq_types_pkg::source_vec_t irq_source,
    input wire logic                       fast_interrupt_request,
    input wire logic                       normal_interrupt_request,
    input wire logic                       event_interrupt
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////
    // bus handshake
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stayed high for more than one cycle");
    a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request taken without ack in the next cycle");
    a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_rdata_holds: assert property ($changed(wb_dat_o) |-> (wb_ack_o && !wb_we_i) || $past(srst))
        else $error("read data changed outside a read answer");

    ////////////////////////////////////////////////////////////////
    // core request outputs follow the lines
    a_fast_needs_line: assert property (fast_interrupt_request |-> irq_source != '0)
        else $error("fast output high with all lines low");
    a_normal_needs_line: assert property (normal_interrupt_request |-> irq_source != '0)
        else $error("normal output high with all lines low");
    a_quiet_lines_idle: assert property (irq_source == '0 |-> !fast_interrupt_request && !normal_interrupt_request)
        else $error("output held after all lines dropped");
    a_fast_stateless: assert property (!$past(wb_cyc_i && wb_stb_i && wb_we_i) &&
        $stable(irq_source) |-> $stable(fast_interrupt_request))
        else $error("fast output moved with lines and registers unchanged");
    a_normal_stateless: assert property (!$past(wb_cyc_i && wb_stb_i && wb_we_i) &&
        $stable(irq_source) |-> $stable(normal_interrupt_request))
        else $error("normal output moved with lines and registers unchanged");

    ////////////////////////////////////////////////////////////////
    // event interrupt moves only for a cause
    a_event_rise_cause: assert property ($rose(event_interrupt) |->
        $past(fast_interrupt_request || normal_interrupt_request || (wb_cyc_i && wb_stb_i)))
        else $error("event interrupt rose without a cause");
    a_event_fall_cause: assert property ($fell(event_interrupt) |->
        $past(srst || (wb_cyc_i && wb_stb_i && wb_we_i)))
        else $error("event interrupt fell without a write");
endmodule

bind vectored_interrupt_controller irq_ctrl_properties i_props
(
    .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_source(irq_source),
    .fast_interrupt_request(fast_interrupt_request),
    .normal_interrupt_request(normal_interrupt_request),
    .event_interrupt(event_interrupt)
);

`default_nettype wire

// [tb/irq_core_model.sv]
// processor core as seen by the controller: samples the request levels
// assumes the core shares the controller's clock
`timescale 1ns/1ps
`default_nettype none

module irq_core_model
(
    // core clock
    input  wire logic clock,
    // request levels from the controller
    input  wire logic fast,
    input  wire logic normal,
    input  wire logic evt,
    // levels as the core saw them at the last edge
    output logic      fast_seen,
    output logic      normal_seen,
    output logic      evt_seen
);
    // the core only acts on levels it has sampled
    always_ff @(posedge clock)
    begin
        fast_seen   <= fast;
        normal_seen <= normal;
        evt_seen    <= evt;
    end
endmodule

`default_nettype wire

// [tb/vectored_interrupt_controller_tb.sv]
// self-checking bench for the interrupt controller
// assumes the design, the core model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

module vectored_interrupt_controller_tb;
    import irq_types_pkg::*;

    logic        clock   = 1'b0;
    logic        srst    = 1'b1;
    logic        wb_cyc  = 1'b0;
    logic        wb_stb  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [11:0] wb_adr  = 12'h000;
    logic [3:0]  wb_sel  = 4'h0;
    word_t       wb_wdat = 32'h0;
    word_t       wb_rdat;
    logic        wb_ack;
    source_vec_t irq_source = 32'h0; // one combined line per peripheral
    logic        fast, normal, evt;
    logic        fast_seen, normal_seen, evt_seen;
    int          fails   = 0;
    int          checked = 0;
    word_t       expq[$];
    logic [11:0] rst_ofs[8] = '{`OFS_CLASS_SELECT, `OFS_ENABLE, `OFS_DEFAULT_ADDR,
        `OFS_SLOT_ADDR, 12'h23c, `OFS_EVT_STATUS, `OFS_FAST_STATUS, `OFS_EVT_CLEAR};

    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////
    // design and core model
    vectored_interrupt_controller i_dut
    (
        .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_source(irq_source),
        .fast_interrupt_request(fast), .normal_interrupt_request(normal),
        .event_interrupt(evt)
    );

    irq_core_model i_core
    (
        .clock(clock), .fast(fast), .normal(normal), .evt(evt),
        .fast_seen(fast_seen), .normal_seen(normal_seen), .evt_seen(evt_seen)
    );

    ////////////////////////////////////////////////////////////////
    // comparison, bus cycles and level checks
    task automatic chk(input word_t seen, input word_t exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [11:0] a, input word_t d, input logic [3:0] s);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= a;
        wb_wdat <= d;
        wb_sel  <= s;
        do
            @(posedge clock);
        while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] a, input word_t d);
        wb(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [11:0] a, input word_t e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask

    // core view of fast, normal and event levels
    task automatic lvl(input logic f, input logic n, input logic e);
        repeat (3) @(posedge clock);
        chk({29'h0, fast_seen, normal_seen, evt_seen}, {29'h0, f, n, e});
    endtask

    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // each read answer is held against the oldest note
    always @(posedge clock)
        if (wb_ack === 1'b1 && wb_we === 1'b0)
            chk(wb_rdat, expq.pop_front());

    // cuts a hang short
    initial
    begin
        #(25 * 5000);
        fails++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////
    // scenarios
    initial
    begin
        word_t a[16];
        word_t cls;
        word_t r;
        word_t e;
        void'($urandom(83));
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        foreach (rst_ofs[i])
            rd(rst_ofs[i], 32'h0);
        wr(12'h3fc, 32'hffff_ffff);
        rd(12'h3fc, 32'h0);
        wr(`OFS_ENABLE, 32'hffff_ffff);
        wr(`OFS_DEFAULT_ADDR, 32'h0000_d000);
        // slot n serves source n at a random address
        for (int n = 0; n < 16; n++)
        begin
            a[n] = $urandom;
            wr(`OFS_SLOT_ADDR + 12'(4 * n), a[n]);
            wr(`OFS_SLOT_CTRL + 12'(4 * n), 32'h20 | 32'(n));
        end
        // each slot beats a non-vectored source; slots 0 to 14 also beat slot 15
        for (int n = 0; n < 16; n++)
        begin
            irq_source <= (32'h1 << n) | 32'h0010_8000;
            rd(`OFS_VECTOR_ADDR, a[n]);
            rd(`OFS_SLOT_ADDR + 12'(4 * n), a[n]);
            rd(`OFS_SLOT_CTRL + 12'(4 * n), 32'h20 | 32'(n));
        end
        lvl(1'b0, 1'b1, 1'b0);
        irq_source <= 32'h0010_0000;
        rd(`OFS_VECTOR_ADDR, 32'h0000_d000);
        rd(`OFS_NONVEC_STATUS, 32'h0010_0000);
        rd(`OFS_NORMAL_STATUS, 32'h0010_0000);
        irq_source <= 32'h0;
        lvl(1'b0, 1'b0, 1'b0);
        wr(`OFS_EVT_CLEAR, 32'h7);
        wr(`OFS_EVT_ENABLE, 32'h7);
        rd(`OFS_EVT_ENABLE, 32'h7);
        rd(`OFS_VECTOR_ADDR, 32'h0000_d000);
        lvl(1'b0, 1'b0, 1'b1);
        wr(`OFS_EVT_CLEAR, 32'h4);
        // two fast sources beside a vectored one
        wr(`OFS_CLASS_SELECT, 32'h18);
        irq_source <= 32'h0000_0218;
        lvl(1'b1, 1'b1, 1'b1);
        rd(`OFS_FAST_STATUS, 32'h18);
        rd(`OFS_VECTOR_ADDR, a[9]);
        rd(`OFS_EVT_STATUS, 32'h3);
        wr(`OFS_EVT_ENABLE, 32'h0);
        lvl(1'b1, 1'b1, 1'b0);
        wr(`OFS_EVT_CLEAR, 32'h3);
        rd(`OFS_EVT_STATUS, 32'h0);
        // a disabled source drops out
        wr(`OFS_ENABLE, 32'hffff_fdff);
        rd(`OFS_ENABLE, 32'hffff_fdff);
        lvl(1'b1, 1'b0, 1'b0);
        rd(`OFS_VECTOR_ADDR, 32'h0000_d000);
        // classes changed while requests stand
        wr(`OFS_CLASS_SELECT, 32'h0);
        lvl(1'b0, 1'b1, 1'b0);
        rd(`OFS_VECTOR_ADDR, a[3]);
        wb(1'b1, `OFS_DEFAULT_ADDR, 32'hffff_ffff, 4'h3);
        rd(`OFS_DEFAULT_ADDR, 32'h0000_ffff);
        // random lines against random classes
        wr(`OFS_ENABLE, 32'hffff_ffff);
        cls = $urandom;
        wr(`OFS_CLASS_SELECT, cls);
        rd(`OFS_CLASS_SELECT, cls);
        repeat (8)
        begin
            r = $urandom;
            irq_source <= r;
            lvl(|(r & cls), |(r & ~cls), 1'b0);
            rd(`OFS_RAW_STATUS, r);
            rd(`OFS_FAST_STATUS, r & cls);
            rd(`OFS_NORMAL_STATUS, r & ~cls);
            rd(`OFS_NONVEC_STATUS, r & ~cls & 32'hffff_0000);
            e = 32'h0000_ffff;
            for (int n = 15; n >= 0; n--)
                if (r[n] && !cls[n])
                    e = a[n];
            rd(`OFS_VECTOR_ADDR, e);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
